// ---- design/csr_pkg.sv ----
// Purpose: constants and carriers for the core special register block
// Assumes: 12-bit data address {sector, location}, 8-bit data
// Notes:   sector 0 special register locations and status bit positions
package csr_pkg;
  localparam int unsigned CSR_DW  = 8;
  localparam int unsigned CSR_AW  = 12;
  localparam int unsigned CSR_PW  = 13;
  localparam logic [7:0] CSR_LOC_IP0  = 8'h00;
  localparam logic [7:0] CSR_LOC_P0   = 8'h01;
  localparam logic [7:0] CSR_LOC_IP1  = 8'h02;
  localparam logic [7:0] CSR_LOC_P1L  = 8'h03;
  localparam logic [7:0] CSR_LOC_P1H  = 8'h04;
  localparam logic [7:0] CSR_LOC_ACC  = 8'h05;
  localparam logic [7:0] CSR_LOC_PCL  = 8'h06;
  localparam logic [7:0] CSR_LOC_TBL  = 8'h07;
  localparam logic [7:0] CSR_LOC_TBR  = 8'h08;
  localparam logic [7:0] CSR_LOC_TBH  = 8'h09;
  localparam logic [7:0] CSR_LOC_STAT = 8'h0A;
  localparam logic [7:0] CSR_LOC_CBS  = 8'h0B;
  localparam logic [7:0] CSR_LOC_IP2  = 8'h0C;
  localparam logic [7:0] CSR_LOC_P2L  = 8'h0D;
  localparam logic [7:0] CSR_LOC_P2H  = 8'h0E;
  localparam logic [3:0] CSR_SEC0     = 4'h0;
  localparam logic [7:0] CSR_ZERO     = 8'h00;
  localparam logic [7:0] CSR_CBS_RST  = 8'h00;
  localparam logic [7:0] CSR_STAT_RST = 8'h00;
  localparam logic [7:0] CSR_STAT_WMSK = 8'hCF;
  localparam int unsigned CSR_B_C  = 0;
  localparam int unsigned CSR_B_HC = 1;
  localparam int unsigned CSR_B_Z  = 2;
  localparam int unsigned CSR_B_SW = 3;
  localparam int unsigned CSR_B_PD = 4;
  localparam int unsigned CSR_B_WE = 5;
  localparam int unsigned CSR_B_CZ = 6;
  localparam int unsigned CSR_B_SX = 7;

  // alu flag update request carried from execution
  typedef struct packed {
    logic       upd;
    logic       arith;
    logic       sub;
    logic       chain_sub;
    logic       plain_sub;
    logic       rot_c;
    logic       rot_cval;
    logic [7:0] res;
    logic       c_out;
    logic       c_in7;
    logic       hc_out;
  } csr_alu_s;

  // one data memory access from the instruction decoder
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        ext;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } csr_acc_s;
endpackage

// ---- design/csr_core.sv ----
// Purpose: special registers, indirect access, status flags, table read
// Assumes: one access per cycle; memory answers reads in the same cycle
// Notes:   work register is the only register-to-register path
// How it works
// - indirect port accesses go to the address held in the pointer
// - indirect port 0 with its pointer reaches sector 0 only
// - ports 1 and 2 use high pointer as sector, low as location
// - indirect port reached through a pointer reads zero, write ignored
// - the five pointers are plain read/write registers
// - extended accesses address any sector directly
// - extended address operand carries twelve bits
// - code bank bit selects program bank for jumps and calls
// - bank register bits 7..1 read zero, bank bit resets to zero
// - no memory-to-memory move; data passes the work register
// - writing counter low byte jumps within current page
// - such a jump inserts one dummy cycle
// - table read: high byte to result register, low byte to target
// - status writes leave watchdog and powerdown flags alone
// - watchdog flag set by timeout, cleared by wdt clear or sleep
// - powerdown flag set by sleep, cleared by wdt clear
// - carry set on carry out or no borrow; rotates update it
// - half carry set on low nibble carry or no nibble borrow
// - zero flag set when result is zero
// - signed wrap when carry into msb differs from carry out
// - sign xor flag is wrap flag xor result msb
// - plain subtracts copy zero flag into chained zero flag
// - status is never pushed on call or interrupt entry
module csr_core
  import csr_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               srst,
  // data access from execution
  input  wire csr_acc_s           acc_req,
  output logic [CSR_DW-1:0]       acc_rdata,
  // general data memory
  output logic                    mem_rd,
  output logic                    mem_wr,
  output logic [CSR_AW-1:0]       mem_addr,
  output logic [CSR_DW-1:0]       mem_wdata,
  input  wire logic [CSR_DW-1:0]  mem_rdata,
  // work register load from alu
  input  wire logic               alu_wr,
  input  wire logic [CSR_DW-1:0]  alu_res,
  output logic [CSR_DW-1:0]       work_q,
  // flags
  input  wire csr_alu_s           alu_flag,
  input  wire logic               wdt_timeout,
  input  wire logic               wdt_clear_instr,
  input  wire logic               sleep_instr,
  output logic [CSR_DW-1:0]       status_q,
  // program counter
  input  wire logic [CSR_PW-1:0]  pc_cur,
  output logic                    pc_jump,
  output logic [CSR_PW-1:0]       pc_target,
  output logic                    dummy_cycle,
  output logic                    code_bank,
  // table read
  input  wire logic               tbl_rd,
  output logic [15:0]             tbl_addr,
  input  wire logic [15:0]        tbl_word,
  output logic [CSR_DW-1:0]       tbl_low
);

  logic [7:0] p0_r, p0_nxt, p1l_r, p1l_nxt, p1h_r, p1h_nxt;
  logic [7:0] p2l_r, p2l_nxt, p2h_r, p2h_nxt, acc_r, acc_nxt;
  logic [7:0] tbl_r, tbl_nxt, tbh_r, tbh_nxt, tbr_r, tbr_nxt;
  logic [7:0] stat_r, stat_nxt, cbs_r, cbs_nxt, tlo_r, tlo_nxt;
  logic       dmy_r, dmy_nxt;
  logic [11:0] eff;
  logic        via_ptr;
  logic        loc_special;

  function automatic logic is_iport(input logic [11:0] a);
    is_iport = (a[11:8] == CSR_SEC0) &&
               (a[7:0] == CSR_LOC_IP0 || a[7:0] == CSR_LOC_IP1 || a[7:0] == CSR_LOC_IP2);
  endfunction

  // address resolution; pointer targets are final, never chased again
  always_comb
  begin
    eff = acc_req.ext ? acc_req.addr : {CSR_SEC0, acc_req.addr[7:0]};
    via_ptr = 1'b0;
    if (is_iport(eff))
    begin
      via_ptr = 1'b1;
      case (eff[7:0])
        CSR_LOC_IP0: eff = {CSR_SEC0, p0_r};
        CSR_LOC_IP1: eff = {p1h_r[3:0], p1l_r};
        default:     eff = {p2h_r[3:0], p2l_r};
      endcase
    end
    loc_special = (eff[11:8] == CSR_SEC0) && (eff[7:0] <= CSR_LOC_P2H);
  end

  // read mux and memory strobes
  always_comb
  begin
    acc_rdata = CSR_ZERO;
    mem_rd    = 1'b0;
    mem_wr    = 1'b0;
    mem_addr  = eff;
    mem_wdata = acc_req.wdata;
    if (via_ptr && is_iport(eff))
      acc_rdata = CSR_ZERO;
    else if (loc_special)
    begin
      case (eff[7:0])
        CSR_LOC_P0:   acc_rdata = p0_r;
        CSR_LOC_P1L:  acc_rdata = p1l_r;
        CSR_LOC_P1H:  acc_rdata = p1h_r;
        CSR_LOC_P2L:  acc_rdata = p2l_r;
        CSR_LOC_P2H:  acc_rdata = p2h_r;
        CSR_LOC_ACC:  acc_rdata = acc_r;
        CSR_LOC_PCL:  acc_rdata = pc_cur[7:0];
        CSR_LOC_TBL:  acc_rdata = tbl_r;
        CSR_LOC_TBR:  acc_rdata = tbr_r;
        CSR_LOC_TBH:  acc_rdata = tbh_r;
        CSR_LOC_STAT: acc_rdata = stat_r;
        CSR_LOC_CBS:  acc_rdata = cbs_r;
        default:      acc_rdata = CSR_ZERO;
      endcase
    end
    else
    begin
      mem_rd    = acc_req.rd;
      mem_wr    = acc_req.wr;
      acc_rdata = mem_rdata;
    end
  end

  // next state for special registers
  always_comb
  begin
    logic wr_sp;
    wr_sp    = acc_req.wr && loc_special && !(via_ptr && is_iport(eff));
    p0_nxt   = p0_r;
    p1l_nxt  = p1l_r;
    p1h_nxt  = p1h_r;
    p2l_nxt  = p2l_r;
    p2h_nxt  = p2h_r;
    acc_nxt  = acc_r;
    tbl_nxt  = tbl_r;
    tbh_nxt  = tbh_r;
    tbr_nxt  = tbr_r;
    stat_nxt = stat_r;
    cbs_nxt  = cbs_r;
    tlo_nxt  = tlo_r;
    pc_jump  = 1'b0;
    if (wr_sp)
    begin
      case (eff[7:0])
        CSR_LOC_P0:   p0_nxt  = acc_req.wdata;
        CSR_LOC_P1L:  p1l_nxt = acc_req.wdata;
        CSR_LOC_P1H:  p1h_nxt = acc_req.wdata;
        CSR_LOC_P2L:  p2l_nxt = acc_req.wdata;
        CSR_LOC_P2H:  p2h_nxt = acc_req.wdata;
        CSR_LOC_ACC:  acc_nxt = acc_req.wdata;
        CSR_LOC_PCL:  pc_jump = 1'b1;
        CSR_LOC_TBL:  tbl_nxt = acc_req.wdata;
        CSR_LOC_TBR:  tbr_nxt = acc_req.wdata;
        CSR_LOC_TBH:  tbh_nxt = acc_req.wdata;
        CSR_LOC_STAT: stat_nxt = (acc_req.wdata & CSR_STAT_WMSK) |
                                 (stat_r & ~CSR_STAT_WMSK);
        CSR_LOC_CBS:  cbs_nxt = {7'b0, acc_req.wdata[0]};
        default:      ;
      endcase
    end
    if (alu_wr)
      acc_nxt = alu_res;
    if (alu_flag.upd)
    begin
      stat_nxt[CSR_B_Z]  = (alu_flag.res == CSR_ZERO);
      if (alu_flag.arith)
      begin
        stat_nxt[CSR_B_C]  = alu_flag.c_out;
        stat_nxt[CSR_B_HC] = alu_flag.hc_out;
        stat_nxt[CSR_B_SW] = alu_flag.c_in7 ^ alu_flag.c_out;
        stat_nxt[CSR_B_SX] = stat_nxt[CSR_B_SW] ^ alu_flag.res[7];
        // chain qualifiers only count on a subtract, other arithmetic leaves it alone
        if (alu_flag.sub && alu_flag.plain_sub)
          stat_nxt[CSR_B_CZ] = stat_nxt[CSR_B_Z];
        else if (alu_flag.sub && alu_flag.chain_sub)
          stat_nxt[CSR_B_CZ] = stat_r[CSR_B_CZ] & stat_nxt[CSR_B_Z];
      end
      if (alu_flag.rot_c)
        stat_nxt[CSR_B_C] = alu_flag.rot_cval;
    end
    // clears first so a same-cycle set wins
    if (wdt_clear_instr)
    begin
      stat_nxt[CSR_B_WE] = 1'b0;
      stat_nxt[CSR_B_PD] = 1'b0;
    end
    if (sleep_instr)
    begin
      stat_nxt[CSR_B_WE] = 1'b0;
      stat_nxt[CSR_B_PD] = 1'b1;
    end
    if (wdt_timeout)
      stat_nxt[CSR_B_WE] = 1'b1;
    if (tbl_rd)
    begin
      tbr_nxt = tbl_word[15:8];
      tlo_nxt = tbl_word[7:0];
    end
    dmy_nxt = pc_jump;
  end

  // registers; status is held here only, nothing stacks it
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      p0_r <= CSR_ZERO;
      p1l_r <= CSR_ZERO;
      p1h_r <= CSR_ZERO;
      p2l_r <= CSR_ZERO;
      p2h_r <= CSR_ZERO;
      acc_r <= CSR_ZERO;
      tbl_r <= CSR_ZERO;
      tbh_r <= CSR_ZERO;
      tbr_r <= CSR_ZERO;
      stat_r <= CSR_STAT_RST;
      cbs_r <= CSR_CBS_RST;
      tlo_r <= CSR_ZERO;
      dmy_r <= 1'b0;
    end
    else
    begin
      p0_r <= p0_nxt;
      p1l_r <= p1l_nxt;
      p1h_r <= p1h_nxt;
      p2l_r <= p2l_nxt;
      p2h_r <= p2h_nxt;
      acc_r <= acc_nxt;
      tbl_r <= tbl_nxt;
      tbh_r <= tbh_nxt;
      tbr_r <= tbr_nxt;
      stat_r <= stat_nxt;
      cbs_r <= cbs_nxt;
      tlo_r <= tlo_nxt;
      dmy_r <= dmy_nxt;
    end
  end

  // page kept from current counter, only low byte replaced
  assign pc_target   = {pc_cur[CSR_PW-1:8], acc_req.wdata};
  assign dummy_cycle = dmy_r;
  assign code_bank   = cbs_r[0];
  assign tbl_addr    = {tbh_r, tbl_r};
  assign tbl_low     = tlo_r;
  assign work_q      = acc_r;
  assign status_q    = stat_r;

  // checks on flags, routing and register behaviour
  AST_SLEEP_PD: assert property (@(posedge mclk) disable iff (srst)
    sleep_instr && !wdt_timeout |=> status_q[CSR_B_PD] && !status_q[CSR_B_WE])
    else $error("sleep did not set powerdown");
  AST_TIMEOUT: assert property (@(posedge mclk) disable iff (srst)
    wdt_timeout |=> status_q[CSR_B_WE])
    else $error("timeout lost");
  AST_DUMMY: assert property (@(posedge mclk) disable iff (srst)
    pc_jump |=> dummy_cycle ##1 (!dummy_cycle || $past(pc_jump)))
    else $error("no dummy cycle after jump");
  AST_BANK_HI: assert property (@(posedge mclk) disable iff (srst)
    cbs_r[7:1] == 7'b0)
    else $error("bank upper bits set");
  AST_TBL: assert property (@(posedge mclk) disable iff (srst)
    tbl_rd |=> {tbr_r, tbl_low} == $past(tbl_word))
    else $error("table result wrong");
  AST_NESTED: assert property (@(posedge mclk) disable iff (srst)
    via_ptr && is_iport(eff) |-> acc_rdata == CSR_ZERO && !mem_wr)
    else $error("nested port access leaked");
  AST_P0_SEC: assert property (@(posedge mclk) disable iff (srst)
    !acc_req.ext && acc_req.addr[7:0] == CSR_LOC_IP0 |-> eff[11:8] == CSR_SEC0)
    else $error("port 0 left sector 0");
  AST_STAT_PROT: assert property (@(posedge mclk) disable iff (srst)
    !wdt_timeout && !wdt_clear_instr && !sleep_instr |=>
    $stable(status_q[CSR_B_PD]) && $stable(status_q[CSR_B_WE]))
    else $error("protected flag changed");
  AST_PAGE: assert property (@(posedge mclk) disable iff (srst)
    pc_jump |-> pc_target[CSR_PW-1:8] == pc_cur[CSR_PW-1:8])
    else $error("jump left page");
  AST_BANK_WR: assert property (@(posedge mclk) disable iff (srst)
    acc_req.wr && !acc_req.ext && acc_req.addr[7:0] == CSR_LOC_CBS |-> cbs_nxt[0] == acc_req.wdata[0])
    else $error("bank bit not taken");
  AST_WORK_LOAD: assert property (@(posedge mclk) disable iff (srst)
    alu_wr |=> work_q == $past(alu_res))
    else $error("work register not loaded");
  AST_IP0_ROUTE: assert property (@(posedge mclk) disable iff (srst)
    !acc_req.ext && acc_req.addr[7:0] == CSR_LOC_IP0 && p0_r > CSR_LOC_P2H |->
    mem_addr == {CSR_SEC0, p0_r} && mem_wr == acc_req.wr)
    else $error("port 0 not redirected");
  AST_IP1_ROUTE: assert property (@(posedge mclk) disable iff (srst)
    !acc_req.ext && acc_req.addr[7:0] == CSR_LOC_IP1 && p1h_r[3:0] != CSR_SEC0 |->
    mem_addr == {p1h_r[3:0], p1l_r} && mem_rd == acc_req.rd)
    else $error("port 1 not redirected");
  AST_EXT_ADDR: assert property (@(posedge mclk) disable iff (srst)
    acc_req.ext && acc_req.addr[11:8] != CSR_SEC0 |-> mem_addr == acc_req.addr && mem_rd == acc_req.rd)
    else $error("extended address not passed");
  AST_CZ_PLAIN: assert property (@(posedge mclk) disable iff (srst)
    alu_flag.upd && alu_flag.arith && alu_flag.sub && alu_flag.plain_sub |=>
    status_q[CSR_B_CZ] == status_q[CSR_B_Z])
    else $error("chained zero differs on plain subtract");
endmodule

// ---- dv/csr_core_bench.sv ----
// Purpose: self-checking bench for the core special register block
// Assumes: design samples on rising mclk; bench drives on the falling edge
// Notes:   random values come from a fixed seed; corner cases are written by hand
module csr_core_bench
  import csr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk, srst, alu_wr, wdt_timeout, wdt_clear_instr, sleep_instr, tbl_rd;
  logic mem_rd, mem_wr, pc_jump, dummy_cycle, code_bank;
  csr_acc_s acc_req;
  csr_alu_s alu_flag;
  logic [7:0] acc_rdata, mem_wdata, mem_rdata, alu_res, work_q, status_q, tbl_low, v, w, ef;
  logic       ecz;
  logic [11:0] mem_addr;
  logic [12:0] pc_cur, pc_target;
  logic [15:0] tbl_addr, tbl_word;
  int n_mismatch, checks, cycles;
  int seed = 32'h1a0d8be8;
  // pointer and port locations walked by the scenarios
  logic [7:0] ptr_loc [5] = '{CSR_LOC_P0, CSR_LOC_P1L, CSR_LOC_P1H, CSR_LOC_P2L, CSR_LOC_P2H};
  logic [7:0] port_loc [3] = '{CSR_LOC_IP0, CSR_LOC_IP1, CSR_LOC_IP2};

  csr_core dut (.mclk(mclk), .srst(srst), .acc_req(acc_req), .acc_rdata(acc_rdata),
    .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .alu_wr(alu_wr), .alu_res(alu_res), .work_q(work_q),
    .alu_flag(alu_flag), .wdt_timeout(wdt_timeout), .wdt_clear_instr(wdt_clear_instr),
    .sleep_instr(sleep_instr), .status_q(status_q), .pc_cur(pc_cur), .pc_jump(pc_jump),
    .pc_target(pc_target), .dummy_cycle(dummy_cycle), .code_bank(code_bank),
    .tbl_rd(tbl_rd), .tbl_addr(tbl_addr), .tbl_word(tbl_word), .tbl_low(tbl_low));

  // free running clock at 20 MHz
  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // hang guard, far above the 160 or so cycles the sequence needs
  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      n_mismatch = n_mismatch + 1;
      finish_test();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one access per cycle; each call drops every pulse back low
  task automatic put(input logic r, input logic wr, input logic e, input logic [11:0] a,
                     input logic [7:0] d);
    @(negedge mclk);
    acc_req = '{rd: r, wr: wr, ext: e, addr: a, wdata: d};
    {alu_wr, wdt_timeout, wdt_clear_instr, sleep_instr, tbl_rd} = '0;
    alu_flag = '0;
    mem_rdata = 8'($random(seed));
    pc_cur = 13'($random(seed));
    #1;
  endtask

  // expected flags of an addition: carry, half carry, zero, wrap, sign xor
  function automatic logic [7:0] add_flags(input logic [7:0] r, input logic c,
                                           input logic c7, input logic hc);
    logic ov;
    ov = c7 ^ c;
    return {ov ^ r[7], 3'b000, ov, (r == 8'h00), hc, c};
  endfunction

  task automatic finish_test();
    if (n_mismatch == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    {n_mismatch, checks, cycles} = '0;
    {srst, alu_wr, alu_res, wdt_timeout, wdt_clear_instr, sleep_instr, tbl_rd} = '0;
    {acc_req, alu_flag, mem_rdata, pc_cur, tbl_word} = '0;
    srst = 1'b1;
    repeat (12) @(negedge mclk);
    srst = 1'b0;
    put(1, 0, 0, 12'h00B, 8'h00);
    chk(acc_rdata, 16'h0000);
    chk(status_q[5:4], 16'h0000);
    // bank register: only bit 0 sticks
    repeat (4)
    begin
      v = 8'($random(seed));
      put(0, 1, 0, 12'h00B, v);
      put(1, 0, 0, 12'h00B, 8'h00);
      chk(acc_rdata, {15'h0, v[0]});
      chk(code_bank, v[0]);
    end
    // five pointers behave as plain storage
    foreach (ptr_loc[i])
    begin
      v = 8'($random(seed));
      put(0, 1, 0, {4'h0, ptr_loc[i]}, v);
      put(1, 0, 0, {4'h0, ptr_loc[i]}, 8'h00);
      chk(acc_rdata, {8'h00, v});
    end
    // indirect port 0 stays in sector 0 whatever the pointer holds
    put(0, 1, 0, 12'h001, 8'h85);
    put(1, 0, 0, 12'h001, 8'h00);
    chk(acc_rdata, 16'h0085);
    put(1, 0, 0, 12'h000, 8'h00);
    chk({mem_rd, mem_addr}, 16'h1085);
    chk(acc_rdata, mem_rdata);
    // ports 1 and 2 reach any sector through their pairs
    for (int k = 0; k < 6; k++)
    begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      put(0, 1, 0, (k % 2) ? 12'h00E : 12'h004, {4'h0, w[3:0]});
      put(0, 1, 0, (k % 2) ? 12'h00D : 12'h003, v | 8'h10);
      put(0, 1, 0, (k % 2) ? 12'h00C : 12'h002, w);
      chk({mem_wr, mem_addr}, {4'h1, w[3:0], v | 8'h10});
      chk(mem_wdata, w);
    end
    // a pointer aimed at a port of sector 0 reads zero and writes nothing
    foreach (port_loc[i])
    begin
      put(0, 1, 0, 12'h001, port_loc[i]);
      put(1, 0, 0, 12'h000, 8'h00);
      chk({mem_rd, acc_rdata}, 16'h0000);
      put(0, 1, 0, 12'h000, 8'hA5);
      chk(mem_wr, 16'h0000);
    end
    // extended accesses carry the whole twelve-bit address
    repeat (6)
    begin
      v = 8'($random(seed));
      w = 8'($random(seed));
      put(1, 0, 1, {w[3:0] | 4'h1, v}, 8'h00);
      chk({mem_rd, mem_addr}, {4'h1, w[3:0] | 4'h1, v});
      chk(acc_rdata, mem_rdata);
    end
    // work register load and read back
    put(0, 0, 0, 12'h020, 8'h00);
    alu_wr = 1'b1;
    alu_res = 8'($random(seed));
    put(1, 0, 0, 12'h005, 8'h00);
    chk(work_q, alu_res);
    chk(acc_rdata, alu_res);
    // counter low write jumps within the page, then one dummy cycle
    v = 8'($random(seed));
    put(0, 1, 0, 12'h006, v);
    chk({pc_jump, 2'b00, pc_target}, {3'b100, pc_cur[12:8], v});
    put(0, 0, 0, 12'h020, 8'h00);
    chk({pc_jump, dummy_cycle}, 16'h0001);
    put(0, 0, 0, 12'h020, 8'h00);
    chk(dummy_cycle, 16'h0000);
    // table read splits the word between result register and target
    put(0, 1, 0, 12'h007, 8'h3C);
    put(0, 1, 0, 12'h009, 8'h12);
    put(0, 0, 0, 12'h020, 8'h00);
    tbl_rd = 1'b1;
    tbl_word = 16'($random(seed));
    #1;
    chk(tbl_addr, 16'h123C);
    put(1, 0, 0, 12'h008, 8'h00);
    chk(acc_rdata, tbl_word[15:8]);
    chk(tbl_low, tbl_word[7:0]);
    // status writes cannot reach the watchdog and powerdown flags
    put(0, 1, 0, 12'h00A, 8'hFF);
    put(0, 0, 0, 12'h020, 8'h00);
    chk(status_q, 16'h00CF);
    sleep_instr = 1'b1;
    put(0, 0, 0, 12'h020, 8'h00);
    chk(status_q[5:4], 16'h0001);
    wdt_timeout = 1'b1;
    put(0, 1, 0, 12'h00A, 8'h00);
    chk(status_q[5:4], 16'h0003);
    sleep_instr = 1'b1;
    put(0, 0, 0, 12'h020, 8'h00);
    chk(status_q, 16'h0010);
    wdt_clear_instr = 1'b1;
    put(0, 0, 0, 12'h020, 8'h00);
    chk(status_q[5:4], 16'h0000);
    // a timeout in the same cycle as a clear or a sleep wins
    wdt_timeout = 1'b1;
    wdt_clear_instr = 1'b1;
    put(0, 0, 0, 12'h020, 8'h00);
    chk(status_q[5:4], 16'h0002);
    wdt_timeout = 1'b1;
    sleep_instr = 1'b1;
    put(0, 0, 0, 12'h020, 8'h00);
    chk(status_q[5:4], 16'h0003);
    wdt_clear_instr = 1'b1;
    put(0, 0, 0, 12'h020, 8'h00);
    chk(status_q, 16'h0000);
    // random additions, plain and chained subtracts, rotates
    ecz = 1'b0;
    for (int k = 0; k < 24; k++)
    begin
      put(0, 0, 0, 12'h020, 8'h00);
      v = (k < 4) ? 8'h00 : 8'($random(seed));
      w = 8'($random(seed));
      alu_flag = '{upd: 1'b1, arith: 1'b1, sub: k[0], chain_sub: k[0] & k[1],
                   plain_sub: k[0] & !k[1], rot_c: 1'b0, rot_cval: 1'b0, res: v,
                   c_out: w[0], c_in7: w[1], hc_out: w[2]};
      if (k[0])
        ecz = (k[1] ? ecz : 1'b1) & (v == 8'h00);
      ef = add_flags(v, w[0], w[1], w[2]);
      put(0, 0, 0, 12'h020, 8'h00);
      chk(status_q & 8'h8F, ef);
      chk(status_q[6], ecz);
      alu_flag = '{upd: 1'b1, arith: 1'b0, sub: 1'b0, chain_sub: 1'b0, plain_sub: 1'b0,
                   rot_c: 1'b1, rot_cval: w[3], res: v, c_out: 1'b0, c_in7: 1'b0,
                   hc_out: 1'b0};
      put(0, 0, 0, 12'h020, 8'h00);
      chk(status_q[0], w[3]);
    end
    finish_test();
  end
endmodule
